// ---- rtl/tmb_defs.svh ----
// register offsets, field positions, reset values and divider counts of the timer control block
// assumes a 32-bit AXI4-Lite slave with one aligned word per register
`ifndef TMB_DEFS_SVH
`define TMB_DEFS_SVH

// register byte offsets
`define TMB_CTRL_OFS 8'h00
`define TMB_COUNT_OFS 8'h04
`define TMB_STATUS_OFS 8'h08

// control field positions
`define TMB_RUN_BIT 15
`define TMB_IDLE_BIT 13
`define TMB_GATE_BIT 6
`define TMB_PS_HI 5
`define TMB_PS_LO 4
`define TMB_SRC_BIT 1

// writable bits of control, everything else reads zero
`define TMB_CTRL_MASK 16'ha072
`define TMB_CTRL_RESET 16'h0000
`define TMB_COUNT_RESET 16'h0000

// prescaler terminal counts (divide ratio minus one)
`define TMB_TERM_DIV1 8'h00
`define TMB_TERM_DIV8 8'h07
`define TMB_TERM_DIV64 8'h3f
`define TMB_TERM_DIV256 8'hff

// axi responses
`define TMB_RESP_OKAY 2'b00
`define TMB_RESP_SLVERR 2'b10

`endif

// ---- rtl/tmb_pkg.sv ----
// types of the timer control block: prescale choice and control fields
// assumes tmb_defs.svh supplies the numeric constants
package tmb_pkg;

    // prescale field encodings
    typedef enum logic [1:0] {
        TMB_PS_1 = 2'b00,
        TMB_PS_8 = 2'b01,
        TMB_PS_64 = 2'b10,
        TMB_PS_256 = 2'b11
    } tmb_prescale_t;

    // decoded control register fields
    typedef struct packed {
        logic timer_run_enable;
        logic idle_stop_select;
        logic gate_accumulate_enable;
        tmb_prescale_t input_prescale_select;
        logic clock_source_select;
    } tmb_ctrl_t;

    // status seen by software
    typedef struct packed {
        logic counting;
        logic pin_level;
        logic idle_mode;
        logic pair_wide_mode;
    } tmb_status_t;

endpackage

// ---- rtl/tmb_timer.sv ----
// 16-bit timer with gate, prescale and clock source control behind an AXI4-Lite slave
// assumes one clock aclk, synchronous active-low reset, pin inputs asynchronous
//
// Overview of operation
// RULE1: external source selected makes gate bit irrelevant
// RULE2: internal source: gate bit enables gated accumulation
// RULE3: prescale 00/01/10/11 divides by 1/8/64/256
// RULE4: software clears idle-stop for idle in pair mode
// RULE5: pair mode ignores run, gate, prescale, source
// RULE6: source 1 counts pin rises, 0 instruction clock
// RULE7: idle-stop set halts counting while idle
`timescale 1ns/10ps
`include "tmb_defs.svh"

module tmb_timer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic external_count_pin,
    input wire logic pair_wide_mode,
    input wire logic idle_mode,
    output logic [15:0] count_value,
    output logic count_tick
);
    import tmb_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // write channel: address and data taken in either order
    logic aw_held_r;
    logic w_held_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;

    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire aw_have = aw_held_r | aw_take;
    wire w_have = w_held_r | w_take;
    wire [7:0] wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
    wire [31:0] wr_data = w_held_r ? w_data_r : s_axi_wdata;
    wire [3:0] wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;
    wire wr_fire = aw_have & w_have & ~bvalid_r;
    wire wr_ctrl = wr_fire & (wr_addr == `TMB_CTRL_OFS);
    wire wr_count = wr_fire & (wr_addr == `TMB_COUNT_OFS);
    wire wr_known = wr_ctrl | wr_count | (wr_addr == `TMB_STATUS_OFS);

    // byte lanes 0 and 1 merge into the 16-bit registers
    wire [15:0] lane_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

    // hold each channel after acceptance until the response goes out
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else begin
            aw_held_r <= aw_have & ~wr_fire;
            w_held_r <= w_have & ~wr_fire;
            if (aw_take) aw_addr_r <= s_axi_awaddr;
            if (w_take) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
        end
    end

    // write response; unmapped addresses answer slverr
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= `TMB_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_known ? `TMB_RESP_OKAY : `TMB_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // each ready drops while its own channel is held or a response is pending
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= ~(aw_have & ~wr_fire) & ~(wr_fire | bvalid_r);
            s_axi_wready <= ~(w_have & ~wr_fire) & ~(wr_fire | bvalid_r);
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    ////////////////////////////////////////////////////////////////////////////
    // control register
    logic [15:0] ctrl_r;
    wire [15:0] ctrl_nxt = (ctrl_r & ~lane_mask) | (wr_data[15:0] & lane_mask & `TMB_CTRL_MASK);
    tmb_ctrl_t ctrl;

    assign ctrl.timer_run_enable = ctrl_r[`TMB_RUN_BIT];
    assign ctrl.idle_stop_select = ctrl_r[`TMB_IDLE_BIT];
    assign ctrl.gate_accumulate_enable = ctrl_r[`TMB_GATE_BIT];
    assign ctrl.input_prescale_select = tmb_prescale_t'(ctrl_r[`TMB_PS_HI:`TMB_PS_LO]);
    assign ctrl.clock_source_select = ctrl_r[`TMB_SRC_BIT];

    // software view keeps fields even while pair mode overrides them
    always_ff @(posedge aclk) begin
        if (!aresetn) ctrl_r <= `TMB_CTRL_RESET;
        else if (wr_ctrl) ctrl_r <= ctrl_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin synchroniser; only the second and third stages feed logic
    logic pin_s1_r;
    logic pin_s2_r;
    logic pin_s3_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1_r <= 1'b0;
            pin_s2_r <= 1'b0;
            pin_s3_r <= 1'b0;
        end else begin
            pin_s1_r <= external_count_pin;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // tick source selection
    wire pin_rise = pin_s2_r & ~pin_s3_r;
    wire idle_halt = idle_mode & ctrl.idle_stop_select; // [RULE7]
    // pair mode: the partner owns the counter, local fields have no effect
    wire local_run = ctrl.timer_run_enable & ~pair_wide_mode; // [RULE5]
    // gate only consulted on the internal source; pin acts as the gate there
    wire gate_block = ~ctrl.clock_source_select & ctrl.gate_accumulate_enable & ~pin_s2_r; // [RULE1] [RULE2]
    // internal source is one instruction clock per aclk cycle
    wire src_tick = ctrl.clock_source_select ? pin_rise : 1'b1; // [RULE6]
    wire counting = local_run & ~idle_halt & ~gate_block;
    wire raw_tick = counting & src_tick;

    ////////////////////////////////////////////////////////////////////////////
    // prescaler
    logic [7:0] ps_cnt_r;
    logic [7:0] ps_term;

    always_comb begin
        case (ctrl.input_prescale_select) // [RULE3]
            TMB_PS_1: ps_term = `TMB_TERM_DIV1;
            TMB_PS_8: ps_term = `TMB_TERM_DIV8;
            TMB_PS_64: ps_term = `TMB_TERM_DIV64;
            TMB_PS_256: ps_term = `TMB_TERM_DIV256;
            default: ps_term = `TMB_TERM_DIV1;
        endcase
    end

    wire ps_wrap = raw_tick & (ps_cnt_r >= ps_term);

    // control or count writes restart the prescaler so a new ratio starts clean
    always_ff @(posedge aclk) begin
        if (!aresetn) ps_cnt_r <= 8'h00;
        else if (wr_ctrl | wr_count | ~local_run) ps_cnt_r <= 8'h00;
        else if (ps_wrap) ps_cnt_r <= 8'h00;
        else if (raw_tick) ps_cnt_r <= ps_cnt_r + 8'h01;
    end

    ////////////////////////////////////////////////////////////////////////////
    // counter; a bus write wins over a tick in the same cycle
    logic [15:0] count_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_r <= `TMB_COUNT_RESET;
            count_tick <= 1'b0;
        end else begin
            count_tick <= ps_wrap & ~wr_count;
            if (wr_count) count_r <= (count_r & ~lane_mask) | (wr_data[15:0] & lane_mask);
            else if (ps_wrap) count_r <= count_r + 16'h0001;
        end
    end

    assign count_value = count_r;

    ////////////////////////////////////////////////////////////////////////////
    // read channel: one outstanding read, answer one cycle after acceptance
    tmb_status_t status;
    logic [31:0] rd_word;

    assign status.counting = counting;
    assign status.pin_level = pin_s2_r;
    assign status.idle_mode = idle_mode;
    assign status.pair_wide_mode = pair_wide_mode;

    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire rd_known = (s_axi_araddr == `TMB_CTRL_OFS) | (s_axi_araddr == `TMB_COUNT_OFS)
                  | (s_axi_araddr == `TMB_STATUS_OFS);

    always_comb begin
        rd_word = 32'h0000_0000;
        if (s_axi_araddr == `TMB_CTRL_OFS) rd_word = {16'h0000, ctrl_r};
        if (s_axi_araddr == `TMB_COUNT_OFS) rd_word = {16'h0000, count_r};
        if (s_axi_araddr == `TMB_STATUS_OFS) rd_word = {28'h0000000, status};
    end

    // data and response stay put until rready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `TMB_RESP_OKAY;
        end else begin
            s_axi_arready <= ~ar_take & ~s_axi_rvalid;
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_known ? `TMB_RESP_OKAY : `TMB_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// ---- test/tmb_timer_properties.sv ----
// checker for tmb_timer: counting against the control fields
// assumes full-word writes; control shadow is fed from bus writes
`timescale 1ns/10ps
`include "tmb_defs.svh"
module tmb_timer_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic external_count_pin,
    input wire logic pair_wide_mode,
    input wire logic idle_mode,
    input wire logic [15:0] count_value,
    input wire logic count_tick
);
    logic [7:0] wa_r;
    logic [15:0] wd_r;
    logic [15:0] ctl_r;
    ////////////////////////////////////////////////////////////////////////
    // shadow commits with the answer, one edge late, so writes mask checks
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wa_r <= 8'h00;
            wd_r <= 16'h0000;
            ctl_r <= 16'h0000;
        end else begin
            if (s_axi_awvalid && s_axi_awready) wa_r <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) wd_r <= s_axi_wdata[15:0];
            if ($rose(s_axi_bvalid) && wa_r == `TMB_CTRL_OFS) ctl_r <= wd_r & `TMB_CTRL_MASK;
        end
    end
    // counting modes seen through the shadow
    wire quiet = !s_axi_wvalid && !s_axi_bvalid;
    wire base = ctl_r[`TMB_RUN_BIT] && !pair_wide_mode && !idle_mode && quiet;
    wire free1 = base && ctl_r[6:1] == 6'h00;
    wire div8 = base && ctl_r[6:1] == 6'h08;
    wire gated = base && ctl_r[6:1] == 6'h20;
    wire ext = base && ctl_r[5:1] == 5'h01;
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_pair_freeze: assert property ((pair_wide_mode && quiet)[*3] |-> $stable(count_value))
        else $error("count moved while paired");
    a_idle_freeze: assert property ((ctl_r[`TMB_IDLE_BIT] && idle_mode && quiet)[*3] |-> $stable(count_value))
        else $error("count moved while idle");
    a_gate_low_hold: assert property ((gated && !external_count_pin)[*8] |-> $stable(count_value))
        else $error("gated count moved with gate low");
    a_gate_high_count: assert property ((gated && external_count_pin)[*8] |-> count_tick)
        else $error("gated count idle with gate high");
    a_free_run_tick: assert property (free1[*4] |-> count_tick)
        else $error("undivided clock missed a step");
    a_div8_gap: assert property (count_tick && div8 |=> (!count_tick)[*7])
        else $error("divide by 8 stepped early");
    a_pin_edge_count: assert property (ext && $rose(external_count_pin) |-> ##[2:6] count_tick)
        else $error("pin edge not counted");
    a_level_no_count: assert property ((ext && external_count_pin)[*8] |-> $stable(count_value))
        else $error("pin level counted");
    c_div8: cover property (div8 && count_tick);
    c_pin_edge: cover property (ext && $rose(external_count_pin));
    c_idle_hold: cover property (ctl_r[`TMB_IDLE_BIT] && idle_mode);
endmodule
bind tmb_timer tmb_timer_properties u_props (.*);

// ---- test/tmb_timer_test.sv ----
// self-checking bench for tmb_timer over its register bus and pins
// assumes full-word strobes and one transfer in flight per channel
`timescale 1ns/10ps
`include "tmb_defs.svh"
module tmb_timer_test;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, external_count_pin, pair_wide_mode, idle_mode;
    logic count_tick;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d, a, b;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [15:0] count_value;
    int err_count, check_count, c;
    int ratio[4] = '{1, 8, 64, 256};
    tmb_timer u_dut (.*);
    ////////////////////////////////////////////////////////////////////////
    // 100 ns clock
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic to_fail;
        err_count++;
        $display("MISMATCH t=%0t wait ran out", $time);
        end_of_test();
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] ad, input logic [31:0] wd, output logic [1:0] rs);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= ad;
        s_axi_wdata <= wd;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            n++;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (s_axi_bvalid !== 1'b1) to_fail();
    endtask
    task automatic rd(input logic [7:0] ad, output logic [31:0] rv, output logic [1:0] rs);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            n++;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        rv = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (s_axi_rvalid !== 1'b1) to_fail();
    endtask
    // edges after the next one, up to the next step pulse
    task automatic gap(output int n);
        n = 0;
        @(posedge aclk);
        while (count_tick !== 1'b1 && n < 600) begin
            @(posedge aclk);
            n++;
        end
        if (n >= 600) to_fail();
    endtask
    task automatic span(output logic [31:0] x, output logic [31:0] y);
        rd(`TMB_COUNT_OFS, x, r);
        repeat (20) @(posedge aclk);
        rd(`TMB_COUNT_OFS, y, r);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {external_count_pin, pair_wide_mode, idle_mode, s_axi_awaddr, s_axi_araddr} = 19'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`TMB_CTRL_OFS, d, r);
        chk(d, 32'h0);
        rd(`TMB_COUNT_OFS, d, r);
        chk(d, 32'h0);
        wr(`TMB_CTRL_OFS, 32'hffff, r);
        chk({30'h0, r}, {30'h0, `TMB_RESP_OKAY});
        rd(`TMB_CTRL_OFS, d, r);
        chk(d, {16'h0, `TMB_CTRL_MASK});
        rd(8'h0c, d, r);
        chk({30'h0, r}, {30'h0, `TMB_RESP_SLVERR});
        wr(8'h0c, 32'h1, r);
        chk({30'h0, r}, {30'h0, `TMB_RESP_SLVERR});
        // status is read-only: a write is answered okay and has no effect
        wr(`TMB_STATUS_OFS, 32'hf, r);
        chk({30'h0, r}, {30'h0, `TMB_RESP_OKAY});
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            wr(`TMB_CTRL_OFS, 32'(32'h8000 | (i << 4)), r);
            gap(c);
            gap(c);
            chk(32'(c + 1), 32'(ratio[i]));
        end
        $display("test prescale done");
        wr(`TMB_CTRL_OFS, 32'h8000, r);
        pair_wide_mode <= 1'b1;
        span(a, b);
        chk(b, a);
        // paired: nothing counts, only the pair flag shows
        rd(`TMB_STATUS_OFS, d, r);
        chk(d, 32'h1);
        pair_wide_mode <= 1'b0;
        for (int s = 0; s < 2; s++) begin
            wr(`TMB_CTRL_OFS, 32'(32'h8000 | (s << 13)), r);
            idle_mode <= 1'b1;
            span(a, b);
            chk(32'(a === b), 32'(s));
            idle_mode <= 1'b0;
        end
        $display("test pair and idle done");
        wr(`TMB_CTRL_OFS, 32'h8040, r);
        span(a, b);
        chk(b, a);
        external_count_pin <= 1'b1;
        span(a, b);
        chk(32'(a === b), 32'h0);
        // gate high: counting and the synced pin level both show
        rd(`TMB_STATUS_OFS, d, r);
        chk(d, 32'hc);
        external_count_pin <= 1'b0;
        $display("test gate done");
        for (int g = 0; g < 2; g++) begin
            wr(`TMB_CTRL_OFS, 32'(32'h8002 | (g << 6)), r);
            wr(`TMB_COUNT_OFS, 32'h0, r);
            repeat (5) begin
                external_count_pin <= 1'b1;
                repeat (10) @(posedge aclk);
                external_count_pin <= 1'b0;
                repeat (10) @(posedge aclk);
            end
            rd(`TMB_COUNT_OFS, d, r);
            chk(d, 32'h5);
            chk({16'h0, count_value}, 32'h5);
        end
        $display("test pin source done");
        end_of_test();
    end
endmodule
